//--- strap_pkg.sv
/*
  Shared types and constants for the soft configuration strap block.
  Assumes a single 250 MHz clock domain and a synchronous active-high reset.
*/
package strap_pkg;

  localparam int LedCount = 8;
  localparam int LedFunWidth = 2;
  localparam int ModeWidth = 3;
  localparam int SyncStages = 3;

  // LED reset constants, not used: the held vector resets to zero
  localparam logic [LedCount-1:0] LedSelectReset = 8'hFF;
  localparam logic [LedFunWidth-1:0] LedFunReset = 2'h0;

  // Operating mode field encodings
  localparam logic [ModeWidth-1:0] ModeAllCapable = 3'h7;
  localparam logic [ModeWidth-1:0] ModeFixed10Half = 3'h0;
  localparam logic [ModeWidth-1:0] ModeFixed10Full = 3'h1;

  // Raw soft-strap vector: pins and tie-offs
  typedef struct packed {
    logic ledSelect;
    logic [LedFunWidth-1:0] ledFunction;
    logic autoCrossover;
    logic fixedCrossover;
    logic negotiation;
  } strap_pins_t;

  // Per-bit EEPROM override values
  typedef struct packed {
    logic [LedCount-1:0] ledSelect;
    logic [LedFunWidth-1:0] ledFunction;
    logic autoCrossover;
    logic fixedCrossover;
    logic negotiation;
  } strap_vec_t;

  localparam int StrapVecWidth = $bits(strap_vec_t);

  // Resolved reset defaults for the LED and Port 1 PHY register logic
  typedef struct packed {
    logic [LedCount-1:0] ledPinSelectBits;
    logic [LedFunWidth-1:0] ledFunctionSelect;
    logic autoCrossoverEnable;
    logic crossoverMdix;
    logic negotiationEnableBit;
    logic speedSelectLowBit;
    logic duplexModeBit;
    logic advert10Full;
    logic advert10Half;
    logic [ModeWidth-1:0] operatingMode;
  } strap_defaults_t;

endpackage

//--- strap_hold_reg.sv
/*
  Holding register for the strap vector with registered read data.
  Assumes same-clock load strobes.
*/
`timescale 1ns/1ps
module strap_hold_reg #(
  parameter int Width = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Load
  input wire logic load,
  input wire logic [Width-1:0] loadData,
  // Read
  output logic [Width-1:0] holdData
);
  // Elaboration-time refusal of an empty register
  if (Width < 1) begin : g_width_check
    $error("strap_hold_reg: Width must be positive");
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      holdData <= '0;
    end else if (load) begin
      holdData <= loadData;
    end
  end
endmodule

//--- soft_strap_defaults.sv
/*
  Soft configuration strap capture, override and default resolution
  for the LED/GPIO selection and the Port 1 PHY.
  Assumes strap pins are asynchronous, and EEPROM loader strobes are on clk.
*/
// Functional notes
// - LED select strap sets pin LED/GPIO default
// - One strap pin feeds eight individually overridable bits
// - LED function straps set matching function bits
// - Override clear: auto-crossover strap enables detection
// - Override set: auto-crossover strap ignored
// - Override and auto-crossover clear: fixed crossover strap picks MDI or MDIX
// - Negotiation strap sets negotiation enable default
// - Negotiation strap shapes speed, duplex, advert, mode
// - Capture on pin reset release; EEPROM overrides
// - Digital reset without EEPROM restores captured values
// - Pins never resampled on digital reset or reload
`timescale 1ns/1ps
module soft_strap_defaults
  import strap_pkg::*;
#(
  parameter int NumLeds = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Strap pins and capture strobe
  input wire strap_pkg::strap_pins_t strapPins,
  input wire logic pinResetRelease,
  // Digital reset / reload and EEPROM loader
  input wire logic digitalReload,
  input wire logic eepromValid,
  input wire logic eepromLoad,
  input wire strap_pkg::strap_vec_t eepromStraps,
  // Crossover override control from the PHY register logic
  input wire logic crossoverOverrideControl,
  // Resolved defaults
  output strap_pkg::strap_defaults_t defaults
);
  import strap_pkg::*;

  // Elaboration-time refusal of a pin count the vector cannot carry
  if (NumLeds != LedCount) begin : g_led_check
    $error("soft_strap_defaults: NumLeds must equal LedCount");
  end

  localparam int PinWidth = $bits(strap_pins_t);

  // Three-stage synchroniser on the strap pins
  logic [PinWidth-1:0] sync1_q, sync2_q, sync3_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= strapPins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Stable pin value: taken only when stages two and three agree
  logic [PinWidth-1:0] stable_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      stable_q <= '0;
    end else if (sync2_q == sync3_q) begin
      stable_q <= sync3_q;
    end
  end

  strap_pins_t pinVal;
  assign pinVal = strap_pins_t'(stable_q);

  // Latched pin values: only a pin/power-on reset release samples them
  strap_vec_t latched_q;
  strap_vec_t latched_d;
  always_comb begin
    latched_d = '0;
    latched_d.ledSelect = {LedCount{pinVal.ledSelect}};
    latched_d.ledFunction = pinVal.ledFunction;
    latched_d.autoCrossover = pinVal.autoCrossover;
    latched_d.fixedCrossover = pinVal.fixedCrossover;
    latched_d.negotiation = pinVal.negotiation;
  end

  logic [StrapVecWidth-1:0] latchedRaw;
  strap_hold_reg #(
    .Width(StrapVecWidth)
  ) u_latched (
    .clk(clk),
    .rst(rst),
    .load(pinResetRelease),
    .loadData(latched_d),
    .holdData(latchedRaw)
  );
  assign latched_q = strap_vec_t'(latchedRaw);

  // Active vector: captured values, EEPROM overrides, restore on reload
  strap_vec_t active_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      active_q <= '0;
    end else if (eepromLoad && eepromValid) begin
      active_q <= eepromStraps;
    end else if (pinResetRelease) begin
      active_q <= latched_d;
    end else if (digitalReload) begin
      active_q <= latched_q;
    end
  end

  // Derived PHY defaults from the negotiation strap
  function automatic logic [ModeWidth-1:0] modeOf(input logic neg);
    modeOf = neg ? ModeAllCapable : ModeFixed10Half;
  endfunction

  strap_defaults_t defaults_d;
  always_comb begin
    defaults_d = '0;
    defaults_d.ledPinSelectBits = active_q.ledSelect;
    defaults_d.ledFunctionSelect = active_q.ledFunction;
    defaults_d.autoCrossoverEnable = 1'b0;
    defaults_d.crossoverMdix = 1'b0;
    if (!crossoverOverrideControl) begin
      defaults_d.autoCrossoverEnable = active_q.autoCrossover;
      if (!active_q.autoCrossover) begin
        defaults_d.crossoverMdix = active_q.fixedCrossover;
      end
    end
    defaults_d.negotiationEnableBit = active_q.negotiation;
    defaults_d.speedSelectLowBit = active_q.negotiation;
    defaults_d.duplexModeBit = active_q.negotiation;
    defaults_d.advert10Full = active_q.negotiation;
    defaults_d.advert10Half = 1'b1;
    defaults_d.operatingMode = modeOf(active_q.negotiation);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      defaults <= '0;
    end else begin
      defaults <= defaults_d;
    end
  end

  a_mdix_ignored: assert property (@(posedge clk) disable iff (rst)
    $past(crossoverOverrideControl) |-> !defaults.autoCrossoverEnable && !defaults.crossoverMdix)
    else $error("crossover strap not ignored under override");

  a_auto_follow: assert property (@(posedge clk) disable iff (rst)
    !$past(crossoverOverrideControl) |-> defaults.autoCrossoverEnable == $past(active_q.autoCrossover))
    else $error("auto crossover default wrong");

  a_fixed_mdix: assert property (@(posedge clk) disable iff (rst)
    !$past(crossoverOverrideControl) && !$past(active_q.autoCrossover)
      |-> defaults.crossoverMdix == $past(active_q.fixedCrossover))
    else $error("fixed crossover default wrong");

  a_led_select: assert property (@(posedge clk) disable iff (rst)
    pinResetRelease && !(eepromLoad && eepromValid)
      |=> ##1 defaults.ledPinSelectBits == {LedCount{$past(pinVal.ledSelect, 2)}})
    else $error("LED select default not from strap");

  a_led_func: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> defaults.ledFunctionSelect == $past(active_q.ledFunction))
    else $error("LED function default wrong");

  a_neg_enable: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> defaults.negotiationEnableBit == $past(active_q.negotiation)
      && defaults.operatingMode == modeOf($past(active_q.negotiation)))
    else $error("negotiation defaults wrong");

  sequence s_reload;
    digitalReload && !pinResetRelease && !(eepromLoad && eepromValid);
  endsequence

  a_reload_restore: assert property (@(posedge clk) disable iff (rst)
    s_reload |=> active_q == $past(latched_q))
    else $error("reload did not restore latched straps");

  a_no_resample: assert property (@(posedge clk) disable iff (rst)
    !pinResetRelease |=> latched_q == $past(latched_q))
    else $error("strap pins resampled without pin reset");

  a_eeprom_wins: assert property (@(posedge clk) disable iff (rst)
    eepromLoad && eepromValid |=> active_q == $past(eepromStraps))
    else $error("EEPROM override not applied");

  a_hold_reg: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> defaults == $past(defaults_d))
    else $error("defaults not registered");
endmodule

//--- eeprom_loader_model.sv
/*
  Behavioural EEPROM loader: one load strobe per request, image otherwise scrambled.
  Assumes requests arrive off the rising edge of clk.
*/
`timescale 1ns/1ps
module eeprom_loader_model
  import strap_pkg::*;
(
  // Clock
  input wire logic clk,
  // Bench requests
  input wire logic go,
  input wire logic present,
  input wire strap_pkg::strap_vec_t image,
  // Loader outputs
  output logic eepromLoad,
  output logic eepromValid,
  output strap_pkg::strap_vec_t eepromStraps
);
  initial begin
    eepromLoad = 1'b0;
    eepromValid = 1'b0;
    eepromStraps = '0;
  end
  // Image only meaningful during the strobe
  always @(posedge clk) begin
    eepromLoad <= go;
    eepromValid <= present;
    eepromStraps <= go ? image : ~eepromStraps;
  end
endmodule

//--- soft_strap_defaults_tb.sv
/*
  Self-checking bench for the strap default block.
  Assumes the loader model file is compiled first.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module soft_strap_defaults_tb;
  import strap_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  strap_pins_t strapPins = '0;
  logic pinResetRelease = 1'b0;
  logic digitalReload = 1'b0;
  logic crossoverOverrideControl = 1'b0;
  logic go = 1'b0;
  logic present = 1'b0;
  strap_vec_t image = '0;
  logic eepromLoad;
  logic eepromValid;
  strap_vec_t eepromStraps;
  strap_defaults_t defaults;
  strap_pins_t p;
  int n_fail = 0;
  int cmp_count = 0;
  always #2 clk = ~clk;
  soft_strap_defaults dut_u (.clk(clk), .rst(rst), .strapPins(strapPins),
    .pinResetRelease(pinResetRelease), .digitalReload(digitalReload),
    .eepromValid(eepromValid), .eepromLoad(eepromLoad), .eepromStraps(eepromStraps),
    .crossoverOverrideControl(crossoverOverrideControl), .defaults(defaults));
  eeprom_loader_model loader_u (.clk(clk), .go(go), .present(present), .image(image),
    .eepromLoad(eepromLoad), .eepromValid(eepromValid), .eepromStraps(eepromStraps));
  function automatic strap_defaults_t expd(logic [7:0] sel, logic [1:0] fn, logic au,
      logic fx, logic ng, logic ov);
    strap_defaults_t d;
    d.ledPinSelectBits = sel;
    d.ledFunctionSelect = fn;
    d.autoCrossoverEnable = au & ~ov;
    d.crossoverMdix = fx & ~au & ~ov;
    d.negotiationEnableBit = ng;
    d.speedSelectLowBit = ng;
    d.duplexModeBit = ng;
    d.advert10Full = ng;
    d.advert10Half = 1'b1;
    d.operatingMode = ng ? ModeAllCapable : ModeFixed10Half;
    return d;
  endfunction
  function automatic strap_defaults_t expp(strap_pins_t s, logic ov);
    return expd({8{s.ledSelect}}, s.ledFunction, s.autoCrossover, s.fixedCrossover,
      s.negotiation, ov);
  endfunction
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic capture(input strap_pins_t s);
    strapPins = s;
    step(6);
    pinResetRelease = 1'b1;
    step(1);
    pinResetRelease = 1'b0;
    step(3);
  endtask
  task automatic load(input logic v, input strap_vec_t img);
    present = v;
    image = img;
    step(2);
    go = 1'b1;
    step(1);
    go = 1'b0;
    step(5);
  endtask
  task automatic tally_and_finish;
    $display("comparisons=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    step(4);
    rst = 1'b0;
    step(1);
    // Every pin combination through capture
    for (int i = 0; i < 64; i++) begin
      p = strap_pins_t'(i[5:0]);
      capture(p);
      `CHK(defaults, expp(p, 1'b0))
      crossoverOverrideControl = 1'b1;
      step(2);
      `CHK(defaults, expp(p, 1'b1))
      crossoverOverrideControl = 1'b0;
      step(2);
    end
    p = strap_pins_t'(6'h3A);
    capture(p);
    crossoverOverrideControl = 1'b1;
    step(2);
    `CHK(defaults, expp(p, 1'b1))
    crossoverOverrideControl = 1'b0;
    step(2);
    `CHK(defaults, expp(p, 1'b0))
    // Per-bit override from the loader
    load(1'b1, {8'hA5, 2'h2, 1'b0, 1'b1, 1'b1});
    `CHK(defaults, expd(8'hA5, 2'h2, 1'b0, 1'b1, 1'b1, 1'b0))
    load(1'b0, {8'h3C, 2'h1, 1'b1, 1'b0, 1'b0});
    `CHK(defaults, expd(8'hA5, 2'h2, 1'b0, 1'b1, 1'b1, 1'b0))
    // Reload ignores the new pin levels
    strapPins = ~p;
    step(6);
    digitalReload = 1'b1;
    step(1);
    digitalReload = 1'b0;
    step(3);
    `CHK(defaults, expp(p, 1'b0))
    tally_and_finish();
  end
endmodule
